// ==== src/swc_top.sv ====
// SYSREF windowing capture: position detector, selectable sampling
// position and deterministic multiframe counter reset.
// Assumes SYSREF tap samples arrive synchronous to the device clock.
// Assumes a host that writes the sample select after reading status.
// Assumes the link layer takes lane, mode and step controls from flops.
// Assumes single-cycle register strobes, never write and read together.
//
// Function
// - Latch SYSREF on deterministic clock edge
// - Measure SYSREF position into status vector
// - Status bit one flags setup/hold risk
// - Sample SYSREF on chosen delayed clock
// - Select field holds chosen bit index
// - Fine step control: zero coarse, one fine
// - Status bits 0 and 23 always one
// - 24 positions reported, 0..15 selectable
// - Periodic SYSREF divisor n positive integer
// - Lanes support 8B/10B and 64B/66B
// - 8B/10B output stays JESD204B compatible
// - Up to four lanes enabled
// - 64B/66B aligns by sync header, not SYNC
// - Device clock clocks all internal logic
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "swc_consts.svh"
module swc_top
  import swc_pkg::*;
(
  // Device clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // SYSREF samples on the 24 delayed clock instances
  input  wire logic [23:0] sysref_taps_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Delay line and link controls
  output logic             fine_step_o,
  output logic             mode_64b66b_o,
  output logic             sync_pin_used_o,
  output logic [3:0]       lane_enable_o,
  // Capture results
  output logic             sysref_captured_o,
  output logic             lmfc_boundary_o
);
  // every clocked process below runs on the device clock clk_i

  // Register port and stored settings
  swc_bus_s          bus;
  swc_ctrl_s         ctrl_q;
  logic [7:0]        period_q;
  logic [2:0]        lanes_d;
  logic [2:0]        lanes_q;
  logic [7:0]        rdata_d;
  logic [7:0]        rdata_q;

  // Window status
  logic [23:0]       win_q;
  logic [23:0]       win_hit;
  logic              clr_win;

  // Link-facing output flops
  logic              fine_q;
  logic              mode_q;
  logic              sync_used_q;
  logic [3:0]        lane_en_q;
  logic              bnd_q;

  // Capture path and counter
  logic              smp_q;
  logic              cap_q;
  logic              cap_d;
  swc_state_e        state_q;
  swc_state_e        state_d;
  logic [7:0]        phase;
  logic              bnd;

  // Register request bundle
  assign bus = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  // Window clear request from a control write
  assign clr_win = bus.wr && (bus.addr == `SWC_OFS_CTRL)
                   && bus.wdata[`SWC_CTRL_CLR_BIT];

  // Control register: select, fine step, encoding mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= swc_ctrl_s'(`SWC_CTRL_RST);
    end else if (bus.wr && (bus.addr == `SWC_OFS_CTRL)) begin
      ctrl_q.sample_select <= bus.wdata[3:0];
      ctrl_q.fine_step     <= bus.wdata[`SWC_CTRL_FINE_BIT];
      ctrl_q.mode_64b66b   <= bus.wdata[`SWC_CTRL_MODE_BIT];
      ctrl_q.clear_window  <= 1'b0; // Clear is self-acting
    end
  end

  // Multiframe period in device clocks minus one
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_q <= `SWC_PERIOD_RST;
    end else if (bus.wr && (bus.addr == `SWC_OFS_PERIOD)) begin
      period_q <= bus.wdata;
    end
  end

  // Lane count clamp, one through four
  always_comb begin
    lanes_d = bus.wdata[2:0];
    if (bus.wdata[2:0] == 3'h0) begin
      lanes_d = 3'h1;
    end else if (bus.wdata[2:0] > `SWC_MAX_LANES) begin
      lanes_d = `SWC_MAX_LANES;
    end
  end

  // Lane count register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lanes_q <= `SWC_LANES_RST;
    end else if (bus.wr && (bus.addr == `SWC_OFS_LANES)) begin
      lanes_q <= lanes_d;
    end
  end

  // Per-position violation detect: a transition next to a tap
  genvar gi;
  generate
    for (gi = 0; gi < `SWC_WIN_BITS; gi++) begin : g_win
      if (gi == 0 || gi == `SWC_WIN_BITS - 1) begin : g_edge
        assign win_hit[gi] = 1'b1;
      end else begin : g_mid
        assign win_hit[gi] =
          (sysref_taps_i[gi] != sysref_taps_i[gi-1]) ||
          (sysref_taps_i[gi] != sysref_taps_i[gi+1]);
      end
    end
  endgenerate

  // Sticky window status; a new hit wins over a clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_q <= `SWC_WIN_RST;
    end else if (clr_win) begin
      win_q <= win_hit;
    end else begin
      win_q <= win_q | win_hit;
    end
  end

  // Sample SYSREF on the chosen delayed clock instance
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      smp_q <= 1'b0;
    end else begin
      smp_q <= sysref_taps_i[ctrl_q.sample_select];
    end
  end

  // Capture sequencer: wait low, arm, take rising edge
  always_comb begin
    state_d = state_q;
    cap_d   = 1'b0;
    case (state_q)
      SWC_WAIT_LOW: begin
        if (!smp_q) begin
          state_d = SWC_ARMED;
        end
      end
      SWC_ARMED: begin
        if (smp_q) begin
          state_d = SWC_CAPTURED;
          cap_d   = 1'b1;
        end
      end
      SWC_CAPTURED: begin
        state_d = SWC_WAIT_LOW;
      end
      default: begin
        state_d = SWC_WAIT_LOW;
      end
    endcase
  end

  // Capture sequencer state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SWC_WAIT_LOW;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture pulse, one cycle per SYSREF rising edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
    end
  end

  // Local multiframe / extended multiblock counter
  swc_lmfc_counter u_lmfc (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .period_i   (period_q),
    .restart_i  (cap_q),
    .phase_o    (phase),
    .boundary_o (bnd)
  );

  // Fine or coarse delay step to the delay line
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fine_q <= 1'b1;
    end else begin
      fine_q <= ctrl_q.fine_step;
    end
  end

  // Line encoding: 8B/10B or 64B/66B
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= ctrl_q.mode_64b66b;
    end
  end

  // SYNC handshake only in 8B/10B; 64B/66B aligns on sync headers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_used_q <= 1'b1;
    end else begin
      sync_used_q <= !ctrl_q.mode_64b66b;
    end
  end

  // Thermometer lane enables from the lane count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_en_q <= 4'h0;
    end else begin
      lane_en_q <= 4'((5'h01 << lanes_q) - 5'h01);
    end
  end

  // Multiframe boundary, re-timed onto an output flop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bnd_q <= 1'b0;
    end else begin
      bnd_q <= bnd;
    end
  end

  // Read mux, zero when no read strobe
  always_comb begin
    rdata_d = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `SWC_OFS_CTRL:     rdata_d = {1'b0, 1'b0, ctrl_q.mode_64b66b,
                                      ctrl_q.fine_step,
                                      ctrl_q.sample_select};
        `SWC_OFS_PERIOD:   rdata_d = period_q;
        `SWC_OFS_LANES:    rdata_d = {5'h00, lanes_q};
        `SWC_OFS_WIN_LOW:  rdata_d = win_q[7:0];
        `SWC_OFS_WIN_MID:  rdata_d = win_q[15:8];
        `SWC_OFS_WIN_HIGH: rdata_d = win_q[23:16];
        `SWC_OFS_STATE:    rdata_d = phase;
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from their flops
  assign reg_rdata_o       = rdata_q;
  assign fine_step_o       = fine_q;
  assign mode_64b66b_o     = mode_q;
  assign sync_pin_used_o   = sync_used_q;
  assign lane_enable_o     = lane_en_q;
  assign sysref_captured_o = cap_q;
  assign lmfc_boundary_o   = bnd_q;
endmodule // swc_top

// ==== src/swc_consts.svh ====
// Constants of the SYSREF windowing capture block.
// Assumes inclusion by bare name from package and modules.
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// Register offsets
`define SWC_OFS_CTRL      8'h29
`define SWC_OFS_PERIOD    8'h2a
`define SWC_OFS_LANES     8'h2b
`define SWC_OFS_WIN_LOW   8'h2c
`define SWC_OFS_WIN_MID   8'h2d
`define SWC_OFS_WIN_HIGH  8'h2e
`define SWC_OFS_STATE     8'h2f

// Control field positions
`define SWC_CTRL_SEL_LSB  0
`define SWC_CTRL_FINE_BIT 4
`define SWC_CTRL_MODE_BIT 5
`define SWC_CTRL_CLR_BIT  6

// Reset values
`define SWC_CTRL_RST      8'h10
`define SWC_PERIOD_RST    8'h1f
`define SWC_LANES_RST     3'h4
`define SWC_WIN_RST       24'h800001

// Window geometry
`define SWC_WIN_BITS      24
`define SWC_SEL_MAX       4'hf
`define SWC_MAX_LANES     3'h4

`endif

// ==== src/swc_pkg.sv ====
// Types of the SYSREF windowing capture block.
// Assumes swc_consts.svh is on the include path.
package swc_pkg;
  `include "swc_consts.svh"

  // Software control word
  typedef struct packed {
    logic       clear_window;
    logic       mode_64b66b;
    logic       fine_step;
    logic [3:0] sample_select;
  } swc_ctrl_s;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swc_bus_s;

  // Capture state, one-hot
  typedef enum logic [2:0] {
    SWC_WAIT_LOW  = 3'b001,
    SWC_ARMED     = 3'b010,
    SWC_CAPTURED  = 3'b100
  } swc_state_e;
endpackage

// ==== src/swc_lmfc_counter.sv ====
// Local multiframe / extended multiblock clock counter.
// Assumes one device clock; restart is a one-cycle capture pulse.
`timescale 1ns/10ps
module swc_lmfc_counter
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Control
  input  wire logic [7:0] period_i,
  input  wire logic       restart_i,
  // Status
  output logic [7:0]      phase_o,
  output logic            boundary_o
);
  logic [7:0] cnt_q;
  logic       bnd_q;

  // Phase count, forced to zero by a captured SYSREF
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 8'h00;
    end else if (restart_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= period_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Boundary pulse at each wrap or restart
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bnd_q <= 1'b0;
    end else begin
      bnd_q <= restart_i || (cnt_q >= period_i);
    end
  end

  assign phase_o    = cnt_q;
  assign boundary_o = bnd_q;
endmodule // swc_lmfc_counter

// ==== sim/swc_top_monitor.sv ====
// Port checker for the SYSREF windowing capture top.
// Assumes one device clock; bound onto swc_top below.
`timescale 1ns/10ps
module swc_top_monitor (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Outputs
  input wire logic       fine_step_o,
  input wire logic       mode_64b66b_o,
  input wire logic       sync_pin_used_o,
  input wire logic [3:0] lane_enable_o,
  input wire logic       sysref_captured_o,
  input wire logic       lmfc_boundary_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Reads of the window edge bytes and control register writes
  sequence rd_low;
    reg_rd_i && reg_addr_i == 8'h2c;
  endsequence
  sequence rd_high;
    reg_rd_i && reg_addr_i == 8'h2e;
  endsequence
  sequence ctrl_wr;
    reg_wr_i && reg_addr_i == 8'h29;
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  win_low_edge_a: assert property (rd_low |=> reg_rdata_o[0])
    else $error("window bit 0 not set");
  win_high_edge_a: assert property (rd_high |=> reg_rdata_o[7])
    else $error("window bit 23 not set");
  fine_follow_a: assert property (ctrl_wr |->
    ##2 fine_step_o == $past(reg_wdata_i[4], 2))
    else $error("fine step output does not follow control");
  mode_follow_a: assert property (ctrl_wr |->
    ##2 mode_64b66b_o == $past(reg_wdata_i[5], 2))
    else $error("encoding mode output does not follow control");
  sync_mode_a: assert property (sync_pin_used_o != mode_64b66b_o)
    else $error("sync pin use disagrees with mode");
  capture_single_a: assert property (
    sysref_captured_o |=> !sysref_captured_o[*2])
    else $error("capture pulse too long");
  boundary_follow_a: assert property (
    sysref_captured_o |-> ##2 lmfc_boundary_o)
    else $error("no counter restart after capture");
  lane_therm_a: assert property ($past(resetn_i) |->
    lane_enable_o inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("lane enables not a legal set");
endmodule // swc_top_monitor

bind swc_top swc_top_monitor i_mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .fine_step_o(fine_step_o), .mode_64b66b_o(mode_64b66b_o),
  .sync_pin_used_o(sync_pin_used_o), .lane_enable_o(lane_enable_o),
  .sysref_captured_o(sysref_captured_o),
  .lmfc_boundary_o(lmfc_boundary_o));

// ==== sim/swc_clock_source.sv ====
// Model of the clock source: one SYSREF pulse seen on 24 delayed taps.
// Assumes fire_i is a one-cycle request; pulses spaced by the bench.
`timescale 1ns/10ps
module swc_clock_source (
  // Clock and request
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic [4:0]  pos_i,
  // SYSREF per delayed tap
  output logic [23:0]      taps_o
);
  logic [2:0] cnt_q = 3'h0;
  // Pulse phase: rise, high, high, fall
  always @(posedge clk_i) begin
    if (fire_i) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  // Later taps see each edge first; low at least one cycle after
  always_comb begin
    case (cnt_q)
      3'h4: taps_o = 24'hffffff << pos_i;
      3'h3, 3'h2: taps_o = 24'hffffff;
      3'h1: taps_o = ~(24'hffffff << pos_i);
      default: taps_o = 24'h000000;
    endcase
  end
endmodule // swc_clock_source

// ==== sim/testbench.sv ====
// Self-checking bench for the SYSREF windowing capture top.
// Assumes the clock source model drives the tap vector.
`timescale 1ns/10ps
module testbench;
  import swc_pkg::*;
  logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, fire, fine, mode, sync;
  logic        cap, bnd;
  logic [7:0]  reg_addr_i, reg_wdata_i, rdata, v, w;
  logic [4:0]  pos;
  logic [23:0] taps;
  logic [3:0]  lanes;
  int          mismatches, compares, n;

  // Design and clock source
  swc_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sysref_taps_i(taps),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .fine_step_o(fine), .mode_64b66b_o(mode), .sync_pin_used_o(sync),
    .lane_enable_o(lanes), .sysref_captured_o(cap),
    .lmfc_boundary_o(bnd));
  swc_clock_source i_src (.clk_i(clk_i), .fire_i(fire), .pos_i(pos),
    .taps_o(taps));

  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(string s, logic [7:0] a, logic [7:0] e);
    rd(a, v);
    chk(s, e, v);
  endtask
  task automatic lane(logic [7:0] d, logic [3:0] e);
    wr(8'h2b, d);
    repeat (2) @(posedge clk_i);
    #1 chk("lanes", {4'h0, e}, {4'h0, lanes});
  endtask
  task automatic capt(logic [3:0] sel, logic [4:0] p, int e);
    wr(8'h29, {4'h1, sel});
    pos  <= p;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (cap !== 1'b1 && n < 20);
    chk("capture delay", e[7:0], n[7:0]);
    repeat (2) @(posedge clk_i);
    #1 chk("boundary", 8'h01, {7'h0, bnd});
    rc("phase", 8'h2f, 8'h01);
    repeat (8) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, fire} = 4'h0;
    {reg_addr_i, reg_wdata_i, pos} = 21'h0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values, unmapped and read-only places
    rc("ctrl", 8'h29, 8'h10);
    rc("period", 8'h2a, 8'h1f);
    rc("lane count", 8'h2b, 8'h04);
    rc("win low", 8'h2c, 8'h01);
    rc("win mid", 8'h2d, 8'h00);
    rc("win high", 8'h2e, 8'h80);
    rc("unmapped", 8'h30, 8'h00);
    wr(8'h2c, 8'hff);
    rc("win ro", 8'h2c, 8'h01);
    // Lane counts within and beyond the limits
    lane(8'h00, 4'h1);
    lane(8'h02, 4'h3);
    lane(8'h07, 4'hf);
    // Coarse steps with 64B/66B mode
    wr(8'h29, 8'h20);
    repeat (2) @(posedge clk_i);
    #1 chk("fine", 8'h00, {7'h0, fine});
    chk("mode", 8'h01, {7'h0, mode});
    chk("sync used", 8'h00, {7'h0, sync});
    rc("ctrl back", 8'h29, 8'h20);
    // Capture on chosen taps, edge either side of it
    capt(4'h5, 5'h03, 2);
    capt(4'hf, 5'h10, 3);
    capt(4'h0, 5'h00, 2);
    // Clear window, then measure one edge
    wr(8'h29, 8'h50);
    rc("clr low", 8'h2c, 8'h01);
    rc("clr high", 8'h2e, 8'h80);
    pos  <= 5'h08;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(8'h2c, v);
    rd(8'h2d, w);
    chk("edge flag", 8'h01, {7'h0, v[7] | w[0]});
    chk("quiet flag", 8'h00, {7'h0, v[3]});
    chk("win low", 8'h81, v);
    chk("win mid", 8'h01, w);
    // Power-up again: stored selection rewritten
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rc("ctrl reset", 8'h29, 8'h10);
    capt(4'h3, 5'h08, 3);
    end_sim();
  end
endmodule // testbench
